// ### include/mrr_pkg.sv
// Purpose: shared constants for the memory remap and reset status block
// Assumes: byte addresses on a 32-bit core bus
// Notes:   offsets, sizes and reset values live here only
package mrr_pkg;

  // ****************************************************************
  // address map
  // ****************************************************************
  localparam logic [31:0] MRR_ALIAS_BASE  = 32'h0000_0000;
  localparam logic [31:0] MRR_ALIAS_SIZE  = 32'h0001_0000;
  localparam logic [31:0] MRR_SRAM_BASE   = 32'h0004_0000;
  localparam logic [31:0] MRR_SRAM_SIZE   = 32'h0000_1000;
  localparam logic [31:0] MRR_FLASH_BASE  = 32'h0008_0000;
  localparam logic [31:0] MRR_FLASH_SIZE  = 32'h0001_0000;
  localparam logic [31:0] MRR_BOOT_SIZE   = 32'h0000_0800;
  // register area starts here so the remap and cause registers fall inside it
  localparam logic [31:0] MRR_MMR_BASE    = 32'hFFFF_0000;
  localparam logic [31:0] MRR_MMR_SIZE    = 32'h0000_1000;
  // hidden boot code sits in the top of flash, so vectors at zero stay visible
  localparam logic [31:0] MRR_BOOT_OFF    = MRR_FLASH_SIZE - MRR_BOOT_SIZE;
  localparam logic [31:0] MRR_VEC_TOP     = 32'h0000_0020;
  localparam logic [31:0] MRR_RESET_VEC   = 32'h0000_0000;

  // ****************************************************************
  // registers
  // ****************************************************************
  localparam logic [31:0] MRR_REMAP_ADDR  = 32'hFFFF_0220;
  localparam logic [31:0] MRR_RSTST_ADDR  = 32'hFFFF_0230;
  localparam logic [31:0] MRR_RSTCL_ADDR  = 32'hFFFF_0234;
  localparam int          MRR_REMAP_BIT   = 0;
  localparam int          MRR_POR_BIT     = 0;
  localparam int          MRR_WDT_BIT     = 1;
  localparam int          MRR_SW_BIT      = 2;
  localparam int          MRR_EXT_BIT     = 3;
  localparam logic [7:0]  MRR_REMAP_RST   = 8'h00;
  localparam logic [3:0]  MRR_CAUSE_MASK  = 4'hF;

  // ****************************************************************
  // boot sequencing
  // ****************************************************************
  localparam int          MRR_BOOT_CYC    = 16;
  localparam int          MRR_SWRST_CYC   = 4;

  typedef enum logic [1:0] {
    MRR_ST_RESET = 2'b00,
    MRR_ST_BOOT  = 2'b01,
    MRR_ST_RUN   = 2'b11
  } mrr_state_e;

  typedef enum logic [2:0] {
    MRR_RG_NONE  = 3'd0,
    MRR_RG_FLASH = 3'd1,
    MRR_RG_SRAM  = 3'd2,
    MRR_RG_MMR   = 3'd3,
    MRR_RG_BOOT  = 3'd4
  } mrr_region_e;

endpackage

// ### include/mrr_sram_if.sv
// Purpose: carrier between the decoder and the sram array
// Assumes: one access per cycle, read data one cycle later
// Notes:   byte enables give little endian lane placement
`timescale 1ns/1ps
interface mrr_sram_if #(parameter int AW = 10);
  logic          req;
  logic          we;
  logic [AW-1:0] idx;
  logic [3:0]    be;
  logic [31:0]   wdata;
  logic [31:0]   rdata;
  modport ctrl (output req, output we, output idx, output be, output wdata, input rdata);
  modport mem  (input req, input we, input idx, input be, input wdata, output rdata);
endinterface

// ### rtl/mrr_sram.sv
// Purpose: 32-bit wide sram array with byte lanes
// Assumes: synchronous read, one cycle latency
// Notes:   contents are kept across every reset
`timescale 1ns/1ps
module mrr_sram #(
  parameter int WORDS = 1024,
  parameter int AW    = 10
) (
  input  wire logic clk_i,   // core clock
  mrr_sram_if.mem   bus      // access port
);

  logic [31:0] mem_q [WORDS];
  logic [31:0] rdata_q;

  // byte lane k holds bits 8k+7..8k, lowest address in lane 0
  always_ff @(posedge clk_i) begin
    if (bus.req && bus.we) begin
      for (int k = 0; k < 4; k++) begin
        if (bus.be[k]) begin
          mem_q[bus.idx][8*k +: 8] <= bus.wdata[8*k +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (bus.req && !bus.we) begin
      rdata_q <= mem_q[bus.idx];
    end
  end

  assign bus.rdata = rdata_q;

endmodule

// ### rtl/mrr_top.sv
// Purpose: address decode, remap control and reset cause status
// Assumes: core bus with one request per cycle, answer one cycle later
// Notes:   flash array and peripheral registers sit outside this block
//
// Functional notes
// - lowest 64 kB is an alias window onto flash or sram
// - 4 kB at 0xFFFF0000 holds the peripheral register area
// - access to any undefined address answers with a data abort
// - multi-byte data is little endian, low byte at low address
// - sram is 1024 words of 32 bits at 0x40000
// - sram takes byte, halfword and word accesses, word in one cycle
// - vectors up to 0x20 come from whatever is mapped at zero
// - remap bit 0 set puts sram at address zero
// - remap bit 0 clear puts flash back at address zero
// - every reset clears the remap bit
// - after reset a hidden boot routine runs, then reset vector
// - top 2 kB of flash is boot code, hidden from user code
// - cause bits: 3 external, 1 watchdog, 0 power-on
// - cause bits 7 to 4 always read zero
// - software setting bit 2 triggers a reset, recorded in bit 2
// - writing 1 to the clear register clears the same cause bit
// - clear write leaving bit 2 set triggers another software reset
// - sram valid after power-on only if low-voltage flag status set
`timescale 1ns/1ps
module mrr_top
  import mrr_pkg::*;
#(
  parameter int SRAM_WORDS = 1024,
  parameter int SRAM_AW    = 10
) (
  input  wire logic        clk_i,          // core clock, 125 MHz
  input  wire logic        resetn_i,       // sync reset, active low
  input  wire logic        por_i,          // power-on reset event
  input  wire logic        ext_rst_i,      // external pin reset event
  input  wire logic        wdt_rst_i,      // watchdog timeout event
  input  wire logic        lvf_en_i,       // low_voltage_flag enable from high_voltage_config
  input  wire logic        lvf_stat_i,     // low_voltage_flag status from high_voltage_status
  input  wire logic        req_i,          // core access request
  input  wire logic        we_i,           // write when high
  input  wire logic [1:0]  size_i,         // 0 byte, 1 halfword, 2 word
  input  wire logic [31:0] addr_i,         // byte address
  input  wire logic [31:0] wdata_i,        // write data, lane aligned
  input  wire logic        boot_i,         // access made by boot routine
  input  wire logic [31:0] flash_rdata_i,  // flash read data
  input  wire logic [31:0] mmr_rdata_i,    // peripheral register read data
  output logic             ack_o,          // answer valid
  output logic             abort_o,        // data abort answer
  output logic [31:0]      rdata_o,        // read data
  output logic             flash_req_o,    // flash access
  output logic [15:0]      flash_off_o,    // flash byte offset
  output logic             mmr_req_o,      // peripheral register access
  output logic [11:0]      mmr_off_o,      // peripheral byte offset
  output logic [3:0]       be_o,           // byte lanes of current access
  output logic             sys_rst_o,      // reset to pins and peripherals
  output logic             wdt_rst_o,      // reset to watchdog timer
  output logic             boot_run_o,     // boot routine running
  output logic [31:0]      fetch_vec_o,    // address core fetches when boot ends
  output logic             sram_valid_o,   // sram contents trusted
  output logic             remap_o         // sram mapped at zero
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] b,
                                  input logic [31:0] s);
    return (a >= b) && (a - b < s);
  endfunction

  // little endian lanes: lowest address byte sits in lane 0
  function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a);
    case (sz)
      2'd0:    lanes = 4'b0001 << a;
      2'd1:    lanes = a[1] ? 4'b1100 : 4'b0011;
      default: lanes = 4'b1111;
    endcase
  endfunction

  localparam int BOOT_W = $clog2(MRR_BOOT_CYC + 1);
  localparam int SWR_W  = $clog2(MRR_SWRST_CYC + 1);

  mrr_sram_if #(.AW(SRAM_AW)) sif ();

  mrr_state_e         state_q;
  logic [BOOT_W-1:0]  boot_cnt_q;
  logic [SWR_W-1:0]   swr_cnt_q;
  logic [7:0]         remap_q;
  logic [3:0]         cause_q;
  logic               any_rst;
  logic               sw_trig;
  logic               live;
  logic [31:0]        eff_addr;
  mrr_region_e        region;
  logic [3:0]         be;
  logic               sram_rd_q;
  logic [31:0]        reg_rdata_q;
  logic               reg_rd_q;

  // ****************************************************************
  // decode
  // ****************************************************************
  assign live = req_i && (state_q != MRR_ST_RESET);
  assign be   = lanes(size_i, addr_i[1:0]);

  // alias window folds onto the physical base of the mapped memory
  always_comb begin
    eff_addr = addr_i;
    if (in_rng(addr_i, MRR_ALIAS_BASE, MRR_ALIAS_SIZE)) begin
      eff_addr = (remap_q[MRR_REMAP_BIT] ? MRR_SRAM_BASE : MRR_FLASH_BASE)
                 + (addr_i - MRR_ALIAS_BASE);
    end
  end

  always_comb begin
    region = MRR_RG_NONE;
    if (in_rng(eff_addr, MRR_SRAM_BASE, MRR_SRAM_SIZE)) begin
      region = MRR_RG_SRAM;
    end else if (in_rng(eff_addr, MRR_FLASH_BASE, MRR_FLASH_SIZE)) begin
      // boot area answers only to the boot routine
      if ((eff_addr - MRR_FLASH_BASE) >= MRR_BOOT_OFF && !boot_i) begin
        region = MRR_RG_BOOT;
      end else begin
        region = MRR_RG_FLASH;
      end
    end else if (in_rng(eff_addr, MRR_MMR_BASE, MRR_MMR_SIZE)) begin
      region = MRR_RG_MMR;
    end
  end

  // ****************************************************************
  // sram port
  // ****************************************************************
  assign sif.req   = live && (region == MRR_RG_SRAM);
  assign sif.we    = we_i;
  assign sif.idx   = SRAM_AW'((eff_addr - MRR_SRAM_BASE) >> 2);
  assign sif.be    = be;
  assign sif.wdata = wdata_i;

  mrr_sram #(.WORDS(SRAM_WORDS), .AW(SRAM_AW)) u_sram (
    .clk_i (clk_i),
    .bus   (sif.mem)
  );

  // ****************************************************************
  // reset sequencing
  // ****************************************************************
  assign sw_trig = live && we_i && (
      (addr_i == MRR_RSTST_ADDR && wdata_i[MRR_SW_BIT]) ||
      (addr_i == MRR_RSTCL_ADDR && cause_q[MRR_SW_BIT] && !wdata_i[MRR_SW_BIT]));
  assign any_rst = !resetn_i || por_i || ext_rst_i || wdt_rst_i || (swr_cnt_q != '0);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      swr_cnt_q <= '0;
    end else if (sw_trig) begin
      swr_cnt_q <= SWR_W'(MRR_SWRST_CYC);
    end else if (swr_cnt_q != '0) begin
      swr_cnt_q <= swr_cnt_q - 1'b1;
    end
  end

  // boot routine runs after every reset, then the reset vector
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      state_q    <= MRR_ST_RESET;
      boot_cnt_q <= '0;
    end else begin
      case (state_q)
        MRR_ST_RESET: begin
          state_q    <= MRR_ST_BOOT;
          boot_cnt_q <= BOOT_W'(MRR_BOOT_CYC);
        end
        MRR_ST_BOOT: begin
          if (boot_cnt_q == 1) begin
            state_q <= MRR_ST_RUN;
          end
          boot_cnt_q <= boot_cnt_q - 1'b1;
        end
        MRR_ST_RUN:  state_q <= MRR_ST_RUN;
        default:     state_q <= MRR_ST_RESET;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      remap_q <= MRR_REMAP_RST;
    end else if (live && we_i && addr_i == MRR_REMAP_ADDR) begin
      // upper bits are expected zero from software and stored as given
      remap_q <= wdata_i[7:0];
    end
  end

  // cause bits survive resets except power-on, which leaves bit 0 plus any cause raised in that cycle; a new cause wins over a clear
  always_ff @(posedge clk_i) begin
    logic [3:0] nxt;
    nxt = cause_q;
    if (live && we_i && addr_i == MRR_RSTCL_ADDR) begin
      nxt = nxt & ~wdata_i[3:0];
    end
    if (por_i) begin
      nxt = 4'b0001;
    end
    if (wdt_rst_i) nxt[MRR_WDT_BIT] = 1'b1;
    if (ext_rst_i) nxt[MRR_EXT_BIT] = 1'b1;
    if (sw_trig)   nxt[MRR_SW_BIT]  = 1'b1;
    cause_q <= nxt & MRR_CAUSE_MASK;
  end

  always_ff @(posedge clk_i) begin
    // power-on judges the array and resetn_i clears the verdict; other resets leave it alone
    if (por_i) begin
      sram_valid_o <= lvf_en_i && lvf_stat_i;
    end else if (!resetn_i) begin
      sram_valid_o <= 1'b0;
    end
  end

  // ****************************************************************
  // answer path
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      ack_o       <= 1'b0;
      abort_o     <= 1'b0;
      sram_rd_q   <= 1'b0;
      reg_rd_q    <= 1'b0;
      reg_rdata_q <= '0;
      flash_req_o <= 1'b0;
      mmr_req_o   <= 1'b0;
      flash_off_o <= '0;
      mmr_off_o   <= '0;
      be_o        <= '0;
    end else begin
      ack_o       <= live;
      abort_o     <= live && (region == MRR_RG_NONE || region == MRR_RG_BOOT);
      sram_rd_q   <= sif.req && !we_i;
      reg_rd_q    <= live && !we_i &&
                     (addr_i == MRR_REMAP_ADDR || addr_i == MRR_RSTST_ADDR);
      reg_rdata_q <= (addr_i == MRR_REMAP_ADDR) ? {24'h00_0000, remap_q}
                                                : {28'h000_0000, cause_q};
      flash_req_o <= live && region == MRR_RG_FLASH;
      mmr_req_o   <= live && region == MRR_RG_MMR &&
                     addr_i != MRR_REMAP_ADDR && addr_i != MRR_RSTST_ADDR &&
                     addr_i != MRR_RSTCL_ADDR;
      flash_off_o <= 16'(eff_addr - MRR_FLASH_BASE);
      mmr_off_o   <= eff_addr[11:0];
      be_o        <= be;
    end
  end

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      rdata_o <= '0;
    end else if (sram_rd_q) begin
      rdata_o <= sif.rdata;
    end else if (reg_rd_q) begin
      rdata_o <= reg_rdata_q;
    end else if (flash_req_o) begin
      rdata_o <= flash_rdata_i;
    end else if (mmr_req_o) begin
      rdata_o <= mmr_rdata_i;
    end else begin
      rdata_o <= '0;
    end
  end

  // ****************************************************************
  // status outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    sys_rst_o   <= any_rst;
    wdt_rst_o   <= !resetn_i || por_i;
    boot_run_o  <= !any_rst && state_q != MRR_ST_RUN;
    fetch_vec_o <= MRR_RESET_VEC;
    remap_o     <= any_rst ? 1'b0 : remap_q[MRR_REMAP_BIT];
  end

endmodule

// ### verif/mrr_mem_model.sv
// Purpose: flash array and peripheral register read side facing mrr_top
// Assumes: data wanted while the request stands and the cycle after
// Notes:   after that the lines toggle, so stale data is never read as good
`timescale 1ns/1ps
module mrr_mem_model (
  input  wire logic        clk_i,      // core clock
  input  wire logic        freq_i,     // flash access
  input  wire logic [15:0] foff_i,     // flash byte offset
  input  wire logic        mreq_i,     // register access
  input  wire logic [11:0] moff_i,     // register byte offset
  output logic      [31:0] frd_o,      // flash read data
  output logic      [31:0] mrd_o       // register read data
);
  logic [31:0] fhold_q;
  logic [31:0] mhold_q;
  assign frd_o = freq_i ? {~foff_i, foff_i} : fhold_q;
  assign mrd_o = mreq_i ? {20'h5_A5A5, moff_i} : mhold_q;
  always_ff @(posedge clk_i) begin
    fhold_q <= freq_i ? {~foff_i, foff_i} : ~fhold_q;
    mhold_q <= mreq_i ? {20'h5_A5A5, moff_i} : ~mhold_q;
  end
endmodule

// ### verif/mrr_top_properties.sv
// Purpose: port checks for mrr_top
// Assumes: answer one cycle after a taken request
// Notes:   addr_q mirrors the request address for the answer cycle
`timescale 1ns/1ps
module mrr_top_checker
  import mrr_pkg::*;
(
  input wire logic        clk_i,       // clock
  input wire logic        resetn_i,    // reset, active low
  input wire logic        por_i,       // power-on event
  input wire logic        ext_rst_i,   // pin reset event
  input wire logic        wdt_rst_i,   // watchdog event
  input wire logic        req_i,       // request
  input wire logic        we_i,        // write
  input wire logic [1:0]  size_i,      // size
  input wire logic [31:0] addr_i,      // address
  input wire logic        boot_i,      // boot access
  input wire logic        ack_o,       // answer
  input wire logic        abort_o,     // abort
  input wire logic [31:0] rdata_o,     // read data
  input wire logic        flash_req_o, // flash access
  input wire logic [15:0] flash_off_o, // flash offset
  input wire logic        mmr_req_o,   // register access
  input wire logic [11:0] mmr_off_o,   // register offset
  input wire logic [3:0]  be_o,        // lanes
  input wire logic        sys_rst_o,   // system reset
  input wire logic        wdt_rst_o,   // watchdog reset
  input wire logic        boot_run_o,  // boot phase
  input wire logic [31:0] fetch_vec_o, // fetch address
  input wire logic        remap_o      // sram at zero
);
  logic [31:0] addr_q;
  always_ff @(posedge clk_i) begin
    addr_q <= addr_i;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ****************************************
  // properties
  // ****************************************
  property p_ack_cause; ack_o |-> $past(req_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer with no request");
  property p_hidden; req_i && !boot_i && addr_i[31:11] == 21'h00_011F |=> !ack_o || abort_o; endproperty
  a_hidden: assert property (p_hidden) else $error("boot area reached by user");
  property p_flash_off; flash_req_o |-> flash_off_o == addr_q[15:0]; endproperty
  a_flash_off: assert property (p_flash_off) else $error("flash offset wrong");
  property p_mmr; mmr_req_o |-> mmr_off_o == addr_q[11:0] && addr_q[31:12] == 20'hF_FFF0; endproperty
  a_mmr: assert property (p_mmr) else $error("register area decode wrong");
  property p_sram_zero; req_i && remap_o && addr_i[31:16] == 16'h0000 |=> !flash_req_o; endproperty
  a_sram_zero: assert property (p_sram_zero) else $error("flash seen at zero");
  property p_flash_zero;
    req_i && !remap_o && addr_i[31:16] == 16'h0000 && addr_i[15:11] != 5'h1F
      |=> !ack_o || flash_req_o;
  endproperty
  a_flash_zero: assert property (p_flash_zero) else $error("flash missing at zero");
  property p_be_word; req_i && size_i == 2'd2 |=> !ack_o || abort_o || be_o == 4'hF; endproperty
  a_be_word: assert property (p_be_word) else $error("word lanes wrong");
  property p_be_byte;
    req_i && size_i == 2'd0 |=> !ack_o || abort_o || be_o == (4'h1 << addr_q[1:0]);
  endproperty
  a_be_byte: assert property (p_be_byte) else $error("byte lane wrong");
  property p_rst_remap; por_i || ext_rst_i || wdt_rst_i |-> ##[1:2] (sys_rst_o && !remap_o); endproperty
  a_rst_remap: assert property (p_rst_remap) else $error("reset kept remap");
  property p_wdt_src; wdt_rst_o |-> $past(por_i) || !$past(resetn_i); endproperty
  a_wdt_src: assert property (p_wdt_src) else $error("watchdog reset without power-on");
  property p_cause_hi; req_i && !we_i && addr_i == MRR_RSTST_ADDR |-> ##2 rdata_o[7:4] == 4'h0; endproperty
  a_cause_hi: assert property (p_cause_hi) else $error("cause upper bits set");
  property p_boot_vec; $fell(boot_run_o) |-> fetch_vec_o == MRR_RESET_VEC; endproperty
  a_boot_vec: assert property (p_boot_vec) else $error("fetch not at reset vector");
  cover property (ack_o && abort_o);
  cover property ($rose(remap_o));
  cover property ($fell(boot_run_o));
endmodule
bind mrr_top mrr_top_checker mrr_top_checker_inst (.*);

// ### verif/tb_top.sv
// Purpose: self-checking bench for mrr_top
// Assumes: power-on event held through the first reset
// Notes:   flash data is {~offset, offset}, registers {5A5A5, offset}
`timescale 1ns/1ps
module tb_top;
  import mrr_pkg::*;
  logic clk_i = 0, resetn_i = 0, por_i = 1, ext_rst_i = 0, wdt_rst_i = 0;
  logic lvf_en_i = 1, lvf_stat_i = 1, req_i = 0, we_i = 0, boot_i = 0;
  logic [1:0] size_i = 0;
  logic [31:0] addr_i = 0, wdata_i = 0, flash_rdata_i, mmr_rdata_i, rdata_o, fetch_vec_o, rd;
  logic ack_o, abort_o, flash_req_o, mmr_req_o, sys_rst_o, wdt_rst_o;
  logic boot_run_o, sram_valid_o, remap_o, ab;
  logic [15:0] flash_off_o;
  logic [11:0] mmr_off_o;
  logic [3:0] be_o;
  int err_count = 0, n_compared = 0, n_rst = 0;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (sys_rst_o === 1'b1) n_rst <= n_rst + 1;
  mrr_top mrr_top_inst (.*);
  mrr_mem_model mrr_mem_model_inst (.clk_i(clk_i), .freq_i(flash_req_o), .foff_i(flash_off_o),
    .mreq_i(mmr_req_o), .moff_i(mmr_off_o), .frd_o(flash_rdata_i), .mrd_o(mmr_rdata_i));
  // ****************************************
  // helpers
  // ****************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task acc(input logic w, input logic [1:0] s, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req_i <= 1'b1; we_i <= w; size_i <= s; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
    req_i <= 1'b0;
    #1 ab = abort_o;
    chk(ack_o, 1);
    @(posedge clk_i);
    #1 rd = rdata_o;
  endtask
  task rc(input logic [1:0] s, input logic [31:0] a, e, m, input logic x);
    acc(0, s, a, 0);
    chk(ab, x);
    if (!x) chk(rd & m, e);
  endtask
  task wait_run;
    int n;
    n = 0;
    repeat (3) @(posedge clk_i);
    while ((sys_rst_o !== 1'b0 || boot_run_o !== 1'b0) && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    #1;
  endtask
  task pulse(input int k);
    @(posedge clk_i);
    ext_rst_i <= (k == 0); wdt_rst_i <= (k == 1); por_i <= (k == 2);
    @(posedge clk_i);
    ext_rst_i <= 0; wdt_rst_i <= 0; por_i <= 0;
    wait_run;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_sram;
    acc(1, 2'd2, 32'h0004_0000, 32'h1122_3344);
    acc(1, 2'd1, 32'h0004_0002, 32'hBEEF_0000);
    acc(1, 2'd0, 32'h0004_0FFD, 32'h0000_A500);
    rc(2'd2, 32'h0004_0000, 32'hBEEF_3344, 32'hFFFF_FFFF, 0);
    rc(2'd0, 32'h0004_0001, 32'h0000_3300, 32'h0000_FF00, 0);
    rc(2'd2, 32'h0004_0FFC, 32'h0000_A500, 32'h0000_FF00, 0);
    rc(2'd2, 32'h0004_1000, 0, 0, 1);
    $display("test sram done");
  endtask
  task t_map;
    logic [31:0] bad [5];
    bad = '{32'h0001_0000, 32'h0003_FFFC, 32'h0009_0000, 32'hFFFE_F000, 32'hFFFF_1000};
    acc(1, 2'd0, MRR_REMAP_ADDR, 32'h0000_0001);
    chk(remap_o, 1);
    rc(2'd2, 32'h0000_0000, 32'hBEEF_3344, 32'hFFFF_FFFF, 0);
    rc(2'd0, MRR_REMAP_ADDR, 32'h0000_0001, 32'h0000_00FF, 0);
    acc(1, 2'd0, MRR_REMAP_ADDR, 32'h0000_0000);
    chk(remap_o, 0);
    rc(2'd2, 32'h0000_0000, 32'hFFFF_0000, 32'hFFFF_FFFF, 0);
    rc(2'd2, 32'h0000_0804, 32'hF7FB_0804, 32'hFFFF_FFFF, 0);
    rc(2'd2, 32'h0008_0804, 32'hF7FB_0804, 32'hFFFF_FFFF, 0);
    rc(2'd2, 32'h0008_F810, 0, 0, 1);
    rc(2'd2, 32'h0000_F810, 0, 0, 1);
    @(posedge clk_i) boot_i <= 1;
    rc(2'd2, 32'h0008_F810, 32'h07EF_F810, 32'hFFFF_FFFF, 0);
    @(posedge clk_i) boot_i <= 0;
    rc(2'd2, 32'hFFFF_0004, 32'h5A5A_5004, 32'hFFFF_FFFF, 0);
    foreach (bad[i]) rc(2'd2, bad[i], 0, 0, 1);
    $display("test map done");
  endtask
  task t_cause;
    int r0;
    rc(2'd0, MRR_RSTST_ADDR, 32'h0000_0001, 32'h0000_00FF, 0);
    acc(1, 2'd0, MRR_RSTCL_ADDR, 32'h0000_000F);
    rc(2'd0, MRR_RSTST_ADDR, 0, 32'h0000_00FF, 0);
    acc(1, 2'd0, MRR_REMAP_ADDR, 32'h0000_0001);
    pulse(0);
    chk(remap_o, 0);
    rc(2'd0, MRR_RSTST_ADDR, 32'h0000_0008, 32'h0000_00FF, 0);
    rc(2'd2, 32'h0004_0000, 32'hBEEF_3344, 32'hFFFF_FFFF, 0);
    pulse(1);
    rc(2'd0, MRR_RSTST_ADDR, 32'h0000_000A, 32'h0000_00FF, 0);
    r0 = n_rst;
    acc(1, 2'd0, MRR_RSTST_ADDR, 32'h0000_0004);
    wait_run;
    chk(n_rst > r0, 1);
    rc(2'd0, MRR_RSTST_ADDR, 32'h0000_000E, 32'h0000_00FF, 0);
    r0 = n_rst;
    acc(1, 2'd0, MRR_RSTCL_ADDR, 32'h0000_0002);
    wait_run;
    chk(n_rst > r0, 1);
    rc(2'd0, MRR_RSTST_ADDR, 32'h0000_000C, 32'h0000_00FF, 0);
    r0 = n_rst;
    acc(1, 2'd0, MRR_RSTCL_ADDR, 32'h0000_00FF);
    repeat (8) @(posedge clk_i);
    chk(n_rst > r0, 0);
    acc(1, 2'd0, MRR_RSTST_ADDR, 32'h0000_00F0);
    rc(2'd0, MRR_RSTST_ADDR, 0, 32'h0000_00FF, 0);
    $display("test cause done");
  endtask
  task t_por;
    acc(1, 2'd0, MRR_REMAP_ADDR, 32'h0000_0001);
    @(posedge clk_i) lvf_stat_i <= 0;
    pulse(2);
    chk(sram_valid_o, 0);
    chk(remap_o, 0);
    rc(2'd0, MRR_RSTST_ADDR, 32'h0000_0001, 32'h0000_00FF, 0);
    @(posedge clk_i) lvf_stat_i <= 1;
    pulse(2);
    chk(sram_valid_o, 1);
    $display("test por done");
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1; por_i <= 0;
    wait_run;
    chk(sram_valid_o, 1);
    chk(fetch_vec_o, MRR_RESET_VEC);
    t_sram;
    t_map;
    t_cause;
    t_por;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up;
  end
endmodule
